// [prc_defs.vh]
// register offsets, field positions and reset values of the pressure reference/offset block
// included by prc_top.v and prc_adder.v
`ifndef PRC_DEFS_VH
`define PRC_DEFS_VH
`define PRC_ADDR_W 8
`define PRC_DATA_W 32
`define PRC_OFF_REF_LOW 8'h15
`define PRC_OFF_REF_MID 8'h16
`define PRC_OFF_REF_HIGH 8'h17
`define PRC_OFF_OFS_LOW 8'h18
`define PRC_OFF_OFS_HIGH 8'h19
`define PRC_OFF_RESOLUTION_CONFIG 8'h1a
`define PRC_OFF_OUT_PRESS 8'h1b
`define PRC_OFF_DIFF_PRESS 8'h1c
`define PRC_OFF_STATUS 8'h1d
`define PRC_BYTE_RESET 8'h00
`define PRC_LC_BIT 0
`define PRC_RSV1_BIT 1
`define PRC_SENS_W 24
`define PRC_OFS_W 16
`endif

// [prc_adder.v]
// pressure arithmetic: reference sum and offset-corrected differential pressure
// assumes full-width sensor and reference from the register block, offset sign-extended here, same clock
`timescale 1ns/1ns
`include "prc_defs.vh"
module prc_adder #(
    parameter W = `PRC_SENS_W,
    parameter OW = `PRC_OFS_W
)
(
    input wire mclk_in,
    input wire srst_in,
    input wire [W-1:0] sensor_in,
    input wire [W-1:0] reference_in,
    input wire [OW-1:0] offset_in,
    output reg [W-1:0] sum_out,
    output reg [W-1:0] diff_out
);
    wire signed [W-1:0] ofs_ext;
    assign ofs_ext = {{(W-OW){offset_in[OW-1]}}, offset_in};
    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            sum_out <= {W{1'b0}};
            diff_out <= {W{1'b0}};
        end
        else
        begin
            sum_out <= sensor_in + reference_in; // [R2] [R13]
            diff_out <= sensor_in - reference_in - ofs_ext; // [R5] [R6]
        end
    end
endmodule

// [prc_top.v]
// register bank: reference pressure, calibration offset, resolution config over avalon-mm
// assumes a synchronous avalon master on mclk_in; sensor_in is sampled from another domain
// Notes on behaviour
// [R1] reference high register holds reference bits 23 to 16, read and write
// [R2] full reference is added to measured pressure for the output pressure
// [R3] offset low register holds offset bits 7 to 0
// [R4] offset high register holds offset bits 15 to 8
// [R5] offset word is signed two's complement
// [R6] offset is applied when computing differential pressure
// [R7] software writes zero to config bits 7 to 2
// [R8] software keeps config bit 1 unchanged
// [R9] config bit 0 selects low-current mode, resets to zero
// [R10] software changes low-current bit only while powered down
// [R11] reference low register holds reference bits 7 to 0
// [R12] reference middle register holds reference bits 15 to 8
// [R13] 24-bit reference word is two's complement
// [R14] each written byte takes effect at once, no shadow copy
`timescale 1ns/1ns
`include "prc_defs.vh"
module prc_top #(
    parameter SENS_W = `PRC_SENS_W
)
(
    input wire mclk_in,
    input wire srst_in,
    input wire [`PRC_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [`PRC_DATA_W-1:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [`PRC_DATA_W-1:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire [SENS_W-1:0] sensor_in,
    input wire powered_down_in,
    output reg low_current_select_out,
    output reg [SENS_W-1:0] output_pressure_out,
    output reg [SENS_W-1:0] diff_pressure_out
);
    reg [7:0] reference_pressure_low;
    reg [7:0] reference_pressure_mid;
    reg [7:0] reference_pressure_high;
    reg [7:0] pressure_offset_low;
    reg [7:0] pressure_offset_high;
    reg [7:0] resolution_config;
    reg [SENS_W-1:0] sens_s1;
    reg [SENS_W-1:0] sens_s2;
    reg [SENS_W-1:0] sens_s3;
    reg [SENS_W-1:0] sens_stable;
    reg [2:0] pd_sync;
    reg pd_stable;
    reg lc_change_error;
    reg ack;
    reg [`PRC_DATA_W-1:0] next_readdata;
    wire [SENS_W-1:0] sum_w;
    wire [SENS_W-1:0] diff_w;
    wire req;
    wire wr_go;
    wire rd_go;

    // one wait cycle: every request answered at the second edge it is held
    assign req = avs_read_in | avs_write_in;
    assign wr_go = avs_write_in & ack;
    assign rd_go = avs_read_in & ack;

    function hit;
        input [`PRC_ADDR_W-1:0] a;
        input [`PRC_ADDR_W-1:0] off;
        begin
            hit = (a == off) && avs_byteenable_in[0];
        end
    endfunction

    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            ack <= 1'b0;
            avs_waitrequest_out <= 1'b1;
        end
        else
        begin
            ack <= req & ~ack;
            avs_waitrequest_out <= ~(req & ~ack);
        end
    end

    // input synchronisers; a change counts once stages two and three agree
    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            sens_s1 <= {SENS_W{1'b0}};
            sens_s2 <= {SENS_W{1'b0}};
            sens_s3 <= {SENS_W{1'b0}};
            sens_stable <= {SENS_W{1'b0}};
            pd_sync <= 3'h0;
            pd_stable <= 1'b0;
        end
        else
        begin
            sens_s1 <= sensor_in;
            sens_s2 <= sens_s1;
            sens_s3 <= sens_s2;
            if (sens_s2 == sens_s3)
            begin
                sens_stable <= sens_s3;
            end
            pd_sync <= {pd_sync[1:0], powered_down_in};
            if (pd_sync[1] == pd_sync[2])
            begin
                pd_stable <= pd_sync[2];
            end
        end
    end

    // register writes
    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            reference_pressure_low <= `PRC_BYTE_RESET;
            reference_pressure_mid <= `PRC_BYTE_RESET;
            reference_pressure_high <= `PRC_BYTE_RESET;
            pressure_offset_low <= `PRC_BYTE_RESET;
            pressure_offset_high <= `PRC_BYTE_RESET;
            resolution_config <= `PRC_BYTE_RESET; // [R9]
            lc_change_error <= 1'b0;
        end
        else if (wr_go)
        begin
            if (hit(avs_address_in, `PRC_OFF_REF_LOW))
            begin
                reference_pressure_low <= avs_writedata_in[7:0]; // [R11] [R14]
            end
            else if (hit(avs_address_in, `PRC_OFF_REF_MID))
            begin
                reference_pressure_mid <= avs_writedata_in[7:0]; // [R12] [R14]
            end
            else if (hit(avs_address_in, `PRC_OFF_REF_HIGH))
            begin
                reference_pressure_high <= avs_writedata_in[7:0]; // [R1] [R14]
            end
            else if (hit(avs_address_in, `PRC_OFF_OFS_LOW))
            begin
                pressure_offset_low <= avs_writedata_in[7:0]; // [R3] [R14]
            end
            else if (hit(avs_address_in, `PRC_OFF_OFS_HIGH))
            begin
                pressure_offset_high <= avs_writedata_in[7:0]; // [R4] [R14]
            end
            else if (hit(avs_address_in, `PRC_OFF_RESOLUTION_CONFIG))
            begin
                // bits 7:2 forced zero, bit 1 kept as stored
                resolution_config <= {6'h00, resolution_config[`PRC_RSV1_BIT],
                    avs_writedata_in[`PRC_LC_BIT]}; // [R7] [R8] [R9]
                if ((avs_writedata_in[`PRC_LC_BIT] != resolution_config[`PRC_LC_BIT]) && !pd_stable)
                begin
                    lc_change_error <= 1'b1; // [R10]
                end
            end
        end
        else if (rd_go && hit(avs_address_in, `PRC_OFF_STATUS))
        begin
            lc_change_error <= 1'b0;
        end
    end

    prc_adder #(
        .W(SENS_W),
        .OW(`PRC_OFS_W)
    ) u_adder (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .sensor_in(sens_stable),
        .reference_in({reference_pressure_high, reference_pressure_mid, reference_pressure_low}),
        .offset_in({pressure_offset_high, pressure_offset_low}),
        .sum_out(sum_w),
        .diff_out(diff_w)
    );

    always @*
    begin
        next_readdata = {`PRC_DATA_W{1'b0}};
        if (avs_address_in == `PRC_OFF_REF_LOW)
            next_readdata[7:0] = reference_pressure_low;
        else if (avs_address_in == `PRC_OFF_REF_MID)
            next_readdata[7:0] = reference_pressure_mid;
        else if (avs_address_in == `PRC_OFF_REF_HIGH)
            next_readdata[7:0] = reference_pressure_high;
        else if (avs_address_in == `PRC_OFF_OFS_LOW)
            next_readdata[7:0] = pressure_offset_low;
        else if (avs_address_in == `PRC_OFF_OFS_HIGH)
            next_readdata[7:0] = pressure_offset_high;
        else if (avs_address_in == `PRC_OFF_RESOLUTION_CONFIG)
            next_readdata[7:0] = resolution_config;
        else if (avs_address_in == `PRC_OFF_OUT_PRESS)
            next_readdata[SENS_W-1:0] = sum_w;
        else if (avs_address_in == `PRC_OFF_DIFF_PRESS)
            next_readdata[SENS_W-1:0] = diff_w;
        else if (avs_address_in == `PRC_OFF_STATUS)
            next_readdata[1:0] = {lc_change_error, pd_stable};
    end

    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            avs_readdata_out <= {`PRC_DATA_W{1'b0}};
            low_current_select_out <= 1'b0;
            output_pressure_out <= {SENS_W{1'b0}};
            diff_pressure_out <= {SENS_W{1'b0}};
        end
        else
        begin
            if (avs_read_in & ~ack)
                avs_readdata_out <= next_readdata;
            low_current_select_out <= resolution_config[`PRC_LC_BIT]; // [R9]
            output_pressure_out <= sum_w; // [R2]
            diff_pressure_out <= diff_w; // [R6]
        end
    end
endmodule

// [prc_checker.sv]
// checker: bus handshake, config bit and read data properties of prc_top
// assumes it is bound onto prc_top, one clock, synchronous reset
`timescale 1ns/1ns
module prc_checker (
    input wire mclk_in,
    input wire srst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire low_current_select_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    wire ack = !avs_waitrequest_out;
    wire rd_ack = ack && avs_read_in;
    wire cfg_wr = ack && avs_write_in && avs_byteenable_in[0] && avs_address_in == 8'h1a;
    chk_ack_single: assert property (ack |=> !ack) else $error("ack too long");
    chk_ack_cause: assert property (ack |-> $past(avs_read_in || avs_write_in)) else $error("ack without request");
    chk_idle_wait: assert property (!avs_read_in && !avs_write_in |=> !ack) else $error("ack while idle");
    chk_lc_write: assert property (cfg_wr |-> ##2 low_current_select_out == $past(avs_writedata_in[0], 2))
        else $error("low current bit not written");
    chk_lc_hold: assert property (!cfg_wr |-> ##2 $stable(low_current_select_out))
        else $error("low current bit moved");
    chk_rd_upper: assert property (rd_ack && avs_address_in != 8'h1b && avs_address_in != 8'h1c
        |-> avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
    chk_rd_press_top: assert property (rd_ack && (avs_address_in == 8'h1b || avs_address_in == 8'h1c)
        |-> avs_readdata_out[31:24] == 8'h0) else $error("pressure read upper byte set");
    chk_cfg_reserved: assert property (rd_ack && avs_address_in == 8'h1a |-> avs_readdata_out[7:1] == 7'h0)
        else $error("config reserved bits set");
    chk_unmapped_zero: assert property (rd_ack && (avs_address_in < 8'h15 || avs_address_in > 8'h1d)
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    cov_wr: cover property (ack && avs_write_in);
    cov_rd: cover property (rd_ack);
    cov_lc: cover property (cfg_wr && avs_writedata_in[0]);
endmodule
bind prc_top prc_checker chk (.mclk_in(mclk_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .low_current_select_out(low_current_select_out));

// [pressure_ref_offset_config_tb.sv]
// self-checking bench for prc_top: register access, config bit, pressure sums
// assumes prc_checker is bound onto prc_top
`timescale 1ns/1ns
module pressure_ref_offset_config_tb;
    reg mclk_in = 1'b0;
    reg srst_in = 1'b1;
    reg [7:0] addr = 8'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg [3:0] ben = 4'hf;
    reg [23:0] sens = 24'h0;
    reg pd = 1'b1;
    wire [31:0] rdata;
    wire wait_o;
    wire lc;
    wire [23:0] outp;
    wire [23:0] diffp;
    reg [7:0] regs [0:4];
    reg [31:0] expq [$];
    reg [23:0] refw;
    reg [23:0] exps;
    reg [23:0] expd;
    integer num_errors = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer i;
    always #20 mclk_in = ~mclk_in;
    prc_top dut (.mclk_in(mclk_in), .srst_in(srst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(ben), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_o), .sensor_in(sens), .powered_down_in(pd),
        .low_current_select_out(lc), .output_pressure_out(outp), .diff_pressure_out(diffp));
    task complete_run;
        begin
            $display("errors %0d checks %0d", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk_in);
            addr <= a;
            wdata <= {24'h0, d};
            wr <= w;
            rd <= !w;
            @(posedge mclk_in);
            while (wait_o !== 1'b0) @(posedge mclk_in);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task rdx(input [7:0] a, input [7:0] e);
        begin
            expq.push_back({24'h0, e});
            bus(1'b0, a, 8'h0);
        end
    endtask
    task arith;
        begin
            refw = {regs[2], regs[1], regs[0]};
            repeat (12) @(posedge mclk_in);
            exps = sens + refw;
            expd = sens - refw - {{8{regs[4][7]}}, regs[4], regs[3]};
            check({8'h0, outp}, {8'h0, exps});
            check({8'h0, diffp}, {8'h0, expd});
            expq.push_back({8'h0, exps});
            bus(1'b0, 8'h1b, 8'h0);
            expq.push_back({8'h0, expd});
            bus(1'b0, 8'h1c, 8'h0);
        end
    endtask
    // read monitor takes the oldest expected value at each read acknowledge
    always @(posedge mclk_in)
    begin
        cyc = cyc + 1;
        if (cyc > 3000)
        begin
            num_errors = num_errors + 1;
            complete_run;
        end
        if (rd && wait_o === 1'b0)
            check(rdata, expq.pop_front());
    end
    initial
    begin
        void'($urandom(20));
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rdx(8'h15 + i[7:0], 8'h00);
        repeat (2)
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                regs[i] = 8'($urandom);
                bus(1'b1, 8'h15 + i[7:0], regs[i]);
                rdx(8'h15 + i[7:0], regs[i]);
            end
            sens <= 24'($urandom);
            arith;
        end
        regs[2] = 8'h80;
        bus(1'b1, 8'h17, 8'h80);
        arith;
        ben <= 4'he;
        bus(1'b1, 8'h18, ~regs[3]);
        ben <= 4'hf;
        rdx(8'h18, regs[3]);
        bus(1'b1, 8'h30, 8'h5a);
        rdx(8'h30, 8'h00);
        bus(1'b1, 8'h1a, 8'h01);
        rdx(8'h1a, 8'h01);
        check({31'h0, lc}, 32'h1);
        bus(1'b1, 8'h1a, 8'h00);
        rdx(8'h1a, 8'h00);
        check({31'h0, lc}, 32'h0);
        rdx(8'h1d, 8'h01);
        // leave power-down and change the bit on purpose to reach the sticky error flag
        pd <= 1'b0;
        repeat (6) @(posedge mclk_in);
        bus(1'b1, 8'h1a, 8'h01);
        rdx(8'h1d, 8'h02);
        rdx(8'h1d, 8'h00);
        check({31'h0, lc}, 32'h1);
        repeat (2) @(posedge mclk_in);
        complete_run;
    end
endmodule
